/* logic/wlse_core.v */
// How it works
// - Stack-relative store: low byte, then next address
// - Displacement is signed, -128 to 127
// - Decode CFH, 74H-77H pair select, displacement
// - No condition flag ever changes
// - Immediate stack pointer load stores full word
// - CFH 6EH stack load, low-high, 4 cycles
// - Stack-relative pair load takes 6 cycles
// - Stack-relative pair store takes 6 cycles
`timescale 1ns/1ns
`default_nettype none
`include "wlse_defs.vh"
module wlse_core #(
  parameter PAGE_W = 8
) (
  input wire ref_clk_i, // Core clock
  input wire srst_i, // Synchronous reset, high
  input wire paged_model_i, // Paged configuration strap
  input wire start_i, // First opcode byte valid
  input wire [7:0] op0_i, // First opcode byte
  input wire [7:0] op1_i, // Second byte
  input wire [7:0] op2_i, // Third byte
  input wire [7:0] op3_i, // Fourth byte
  input wire [15:0] pair_ba_i, // Accumulator pair
  input wire [15:0] pair_ptr_i, // Main pointer pair
  input wire [15:0] pair_ix1_i, // First index
  input wire [15:0] pair_ix2_i, // Second index
  input wire [15:0] stack_ptr_i, // Stack pointer
  input wire [PAGE_W-1:0] data_page_i, // Data page register
  input wire [PAGE_W-1:0] index1_page_i, // First index page
  input wire [PAGE_W-1:0] index2_page_i, // Second index page
  input wire [7:0] cond_flags_i, // Condition flags now
  input wire [7:0] mem_rdata_i, // Data memory read data
  output reg [PAGE_W+15:0] mem_addr_o, // Data memory address
  output reg [7:0] mem_wdata_o, // Data memory write data
  output reg mem_rd_o, // Read strobe
  output reg mem_wr_o, // Write strobe
  output reg busy_o, // Instruction in progress
  output reg done_o, // Last cycle pulse
  output reg illegal_o, // Opcode not handled here
  output reg wb_en_o, // Register write-back pulse
  output reg wb_sp_o, // Write-back targets stack pointer
  output reg [1:0] wb_sel_o, // Pair chosen for write-back
  output reg [15:0] wb_data_o, // Write-back word
  output reg [7:0] cond_flags_o // Flags after instruction
);
  localparam S_IDLE = 4'b0001;
  localparam S_WAIT = 4'b0010;
  localparam S_LO = 4'b0100;
  localparam S_HI = 4'b1000;
  reg [3:0] state;
  reg [3:0] cnt;
  reg [3:0] acc_cyc;
  reg is_store;
  reg to_sp;
  reg [1:0] sel;
  reg [2:0] kind;
  reg [15:0] base;
  reg [7:0] disp;
  reg [15:0] store_word;
  reg [7:0] lo_byte;
  reg [PAGE_W-1:0] page_sel;
  reg dec_ok;
  reg dec_store;
  reg dec_sp;
  reg [2:0] dec_kind;
  reg [3:0] dec_cyc;
  reg [15:0] dec_base;
  reg [15:0] dec_pair;
  wire [PAGE_W+15:0] addr_now;
  wire hi_phase;
  assign hi_phase = (state == S_HI);
  always @* begin
    case (op1_i[1:0])
      `WLSE_SEL_BA: dec_pair = pair_ba_i;
      `WLSE_SEL_PTR: dec_pair = pair_ptr_i;
      `WLSE_SEL_IX1: dec_pair = pair_ix1_i;
      default: dec_pair = pair_ix2_i;
    endcase
  end
  always @* begin
    dec_ok = 1'b0;
    dec_store = 1'b0;
    dec_sp = 1'b0;
    dec_kind = `WLSE_KIND_IMM;
    dec_cyc = `WLSE_CYC_LD_IMM;
    dec_base = {op3_i, op2_i};
    if (op0_i == `WLSE_PREFIX) begin
      if (op1_i[7:2] == `WLSE_OP_ST_SPREL) begin
        dec_ok = 1'b1;
        dec_store = 1'b1;
        dec_kind = `WLSE_KIND_SPREL;
        dec_cyc = `WLSE_CYC_SPREL;
        dec_base = stack_ptr_i;
      end else if (op1_i[7:2] == `WLSE_OP_LD_SPREL) begin
        dec_ok = 1'b1;
        dec_kind = `WLSE_KIND_SPREL;
        dec_cyc = `WLSE_CYC_SPREL;
        dec_base = stack_ptr_i;
      end else if (op1_i == `WLSE_OP_LD_SP_IMM) begin
        dec_ok = 1'b1;
        dec_sp = 1'b1;
        dec_cyc = `WLSE_CYC_LD_SP_IMM;
      end
    end
  end
  wlse_addr_gen #(
    .PAGE_W(PAGE_W)
  ) u_addr (
    .base_i(base),
    .disp_i(disp),
    .use_disp_i(kind == `WLSE_KIND_SPREL),
    .hi_byte_i(hi_phase),
    .page_i(page_sel),
    .paged_model_i(paged_model_i),
    .addr_o(addr_now)
  );
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      acc_cyc <= 4'h0;
      is_store <= 1'b0;
      to_sp <= 1'b0;
      sel <= 2'h0;
      kind <= `WLSE_KIND_IMM;
      base <= 16'h0000;
      disp <= 8'h00;
      store_word <= 16'h0000;
      lo_byte <= 8'h00;
      page_sel <= {PAGE_W{1'b0}};
      mem_addr_o <= {(PAGE_W+16){1'b0}};
      mem_wdata_o <= 8'h00;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      wb_en_o <= 1'b0;
      wb_sp_o <= 1'b0;
      wb_sel_o <= 2'h0;
      wb_data_o <= 16'h0000;
      cond_flags_o <= 8'h00;
    end else begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      wb_en_o <= 1'b0;
      cond_flags_o <= cond_flags_i;
      case (state)
        S_IDLE: begin
          if (start_i) begin
            if (dec_ok) begin
              busy_o <= 1'b1;
              is_store <= dec_store;
              to_sp <= dec_sp;
              sel <= op1_i[1:0];
              kind <= dec_kind;
              base <= dec_base;
              disp <= op2_i;
              store_word <= dec_pair;
              if (dec_kind == `WLSE_KIND_IX1) begin
                page_sel <= index1_page_i;
              end else if (dec_kind == `WLSE_KIND_IX2) begin
                page_sel <= index2_page_i;
              end else begin
                page_sel <= data_page_i;
              end
              cnt <= 4'h1;
              acc_cyc <= dec_cyc - 4'h2;
              if (dec_kind == `WLSE_KIND_IMM) begin
                // Immediate word comes straight from the stream
                wb_data_o <= {op3_i, op2_i};
                wb_sp_o <= dec_sp;
                wb_sel_o <= op1_i[1:0];
              end
              state <= S_WAIT;
            end else begin
              illegal_o <= 1'b1;
            end
          end
        end
        S_WAIT: begin
          cnt <= cnt + 4'h1;
          if (kind == `WLSE_KIND_IMM) begin
            if (cnt == acc_cyc + 4'h1) begin
              wb_en_o <= 1'b1;
              done_o <= 1'b1;
              busy_o <= 1'b0;
              state <= S_IDLE;
            end
          end else if (cnt == acc_cyc - 4'h3) begin
            // Two strobes and two returns fill the last four cycles
            state <= S_LO;
          end
        end
        S_LO: begin
          cnt <= cnt + 4'h1;
          mem_addr_o <= addr_now;
          mem_wdata_o <= store_word[7:0];
          mem_wr_o <= is_store;
          mem_rd_o <= ~is_store;
          state <= S_HI;
        end
        S_HI: begin
          cnt <= cnt + 4'h1;
          if (cnt == acc_cyc - 4'h1) begin
            mem_addr_o <= addr_now;
            mem_wdata_o <= store_word[15:8];
            mem_wr_o <= is_store;
            mem_rd_o <= ~is_store;
          end else if (cnt == acc_cyc) begin
            // Read data arrives one cycle after its strobe
            lo_byte <= mem_rdata_i;
          end else begin
            // Last cycle: high byte captured, word handed back
            wb_data_o <= {mem_rdata_i, lo_byte};
            wb_sp_o <= to_sp;
            wb_sel_o <= sel;
            wb_en_o <= ~is_store;
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* logic/wlse_defs.vh */
`ifndef WLSE_DEFS_VH
`define WLSE_DEFS_VH
`define WLSE_PREFIX 8'hCF
`define WLSE_OP_ST_SPREL 6'h1D
`define WLSE_OP_LD_SPREL 6'h1C
`define WLSE_OP_LD_SP_IMM 8'h6E
`define WLSE_CYC_LD_SP_IMM 4'h4
`define WLSE_CYC_LD_ABS 4'h5
`define WLSE_CYC_LD_SP_ABS 4'h6
`define WLSE_CYC_LD_IND 4'h5
`define WLSE_CYC_SPREL 4'h6
`define WLSE_CYC_LD_IMM 4'h3
`define WLSE_SEL_BA 2'h0
`define WLSE_SEL_PTR 2'h1
`define WLSE_SEL_IX1 2'h2
`define WLSE_SEL_IX2 2'h3
`define WLSE_KIND_IMM 3'h0
`define WLSE_KIND_ABS 3'h1
`define WLSE_KIND_PTR 3'h2
`define WLSE_KIND_IX1 3'h3
`define WLSE_KIND_IX2 3'h4
`define WLSE_KIND_SPREL 3'h5
`endif

/* logic/wlse_addr_gen.v */
`timescale 1ns/1ns
`default_nettype none
module wlse_addr_gen #(
  parameter PAGE_W = 8
) (
  input wire [15:0] base_i, // Base 16-bit address
  input wire [7:0] disp_i, // Signed displacement
  input wire use_disp_i, // Add displacement
  input wire hi_byte_i, // Second byte of the word
  input wire [PAGE_W-1:0] page_i, // Selected page register
  input wire paged_model_i, // Page bits in use
  output wire [PAGE_W+15:0] addr_o // Full data address
);
  wire [15:0] disp_ext;
  wire [15:0] eff;
  wire [15:0] low;
  assign disp_ext = use_disp_i ? {{8{disp_i[7]}}, disp_i} : 16'h0000;
  assign eff = base_i + disp_ext;
  assign low = eff + {15'h0000, hi_byte_i};
  // Low half wraps inside 16 bits; page never carries
  assign addr_o = {(paged_model_i ? page_i : {PAGE_W{1'b0}}), low};
endmodule
`default_nettype wire

/* testbench/wlse_chk_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module wlse_chk #(
  parameter PAGE_W = 8
) (
  input wire ref_clk_i, // Core clock
  input wire srst_i, // Reset
  input wire start_i, // Start
  input wire busy_o, // Busy
  input wire [7:0] op0_i, // Byte 0
  input wire [7:0] op1_i, // Byte 1
  input wire [7:0] op2_i, // Offset
  input wire [15:0] stack_ptr_i, // Stack pointer
  input wire [7:0] cond_flags_i, // Flags in
  input wire [7:0] cond_flags_o, // Flags out
  input wire [PAGE_W+15:0] mem_addr_o, // Address
  input wire mem_rd_o, // Read strobe
  input wire mem_wr_o, // Write strobe
  input wire done_o, // Done
  input wire illegal_o // Bad opcode
);
  logic [1:0] cnt;
  logic [15:0] exp_a;
  logic [PAGE_W+15:0] last_a;
  wire acc = start_i & ~busy_o & (op0_i == 8'hCF);
  wire strb = mem_rd_o | mem_wr_o;
  // Byte cycles of one instruction; the count restarts at acceptance
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt <= 2'h0;
      exp_a <= 16'h0;
      last_a <= '0;
    end else if (acc) begin
      cnt <= 2'h0;
      exp_a <= stack_ptr_i + {{8{op2_i[7]}}, op2_i};
    end else if (strb) begin
      cnt <= cnt + 2'h1;
      last_a <= mem_addr_o;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  a_flags_pass: assert property (
    !$past(srst_i) |-> cond_flags_o == $past(cond_flags_i)) else $error("flags");
  a_imm_len: assert property (acc && op1_i == 8'h6E |-> ##4 done_o)
    else $error("imm len");
  a_st_len: assert property (acc && op1_i[7:2] == 6'h1D |-> ##6 done_o)
    else $error("store len");
  a_ld_len: assert property (acc && op1_i[7:2] == 6'h1C |-> ##6 done_o)
    else $error("load len");
  a_imm_no_mem: assert property (acc && op1_i == 8'h6E |=> !strb [*4])
    else $error("imm access");
  a_illegal_next: assert property (
    start_i && !busy_o && op0_i != 8'hCF |=> illegal_o) else $error("illegal");
  a_first_addr: assert property (
    strb && cnt == 2'h0 |-> mem_addr_o[15:0] == exp_a) else $error("addr");
  a_next_addr: assert property (
    strb && cnt == 2'h1 |-> mem_addr_o == {last_a[PAGE_W+15:16], last_a[15:0] + 16'h1})
    else $error("next addr");
  c_store: cover property (mem_wr_o);
  c_load: cover property (mem_rd_o);
  c_illegal: cover property (illegal_o);
endmodule
`default_nettype wire

/* testbench/wlse_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module wlse_mem_model #(
  parameter PAGE_W = 8
) (
  input wire ref_clk_i, // Core clock
  input wire [PAGE_W+15:0] mem_addr_i, // Address
  input wire [7:0] mem_wdata_i, // Write data
  input wire mem_rd_i, // Read strobe
  input wire mem_wr_i, // Write strobe
  output logic [7:0] mem_rdata_o // Read data
);
  logic [7:0] mem [0:65535];
  logic [PAGE_W-1:0] pg;
  initial mem_rdata_o = 8'h5A;
  // Page only recorded for the bench; storage ignores it
  always @(posedge ref_clk_i) begin
    mem_rdata_o <= mem_rd_i ? mem[mem_addr_i[15:0]] : ~mem_rdata_o;
    if (mem_wr_i) mem[mem_addr_i[15:0]] <= mem_wdata_i;
    if (mem_rd_i || mem_wr_i) pg <= mem_addr_i[PAGE_W+15:16];
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam PAGE_W = 8;
  logic ref_clk_i = 1'b0, srst_i = 1'b1, paged_model_i = 1'b1, start_i = 1'b0;
  logic [7:0] op0_i = 8'h0, op1_i = 8'h0, op2_i = 8'h0, op3_i = 8'h0;
  logic [15:0] pair_ba_i = 16'h1122, pair_ptr_i = 16'h3344, stack_ptr_i = 16'h0;
  logic [15:0] pair_ix1_i = 16'h5566, pair_ix2_i = 16'h7788, wb_data_o;
  logic [7:0] data_page_i = 8'h3C, index1_page_i = 8'h4D, index2_page_i = 8'h5E;
  logic [7:0] cond_flags_i = 8'hA5, mem_rdata_i, mem_wdata_o, cond_flags_o;
  logic [PAGE_W+15:0] mem_addr_o;
  logic mem_rd_o, mem_wr_o, busy_o, done_o, illegal_o, wb_en_o, wb_sp_o;
  logic [1:0] wb_sel_o;
  int bad_count = 0, checked = 0, n;
  always #25 ref_clk_i = ~ref_clk_i;
  wlse_core #(.PAGE_W(PAGE_W)) wlse_core_i (.*);
  wlse_mem_model #(.PAGE_W(PAGE_W)) wlse_mem_model_i (.ref_clk_i(ref_clk_i),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rd_i(mem_rd_o),
    .mem_wr_i(mem_wr_o), .mem_rdata_o(mem_rdata_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("bad_count=%0d checked=%0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Returns the cycle in which done shows, counting the first after acceptance as 1
  task automatic run(input logic [7:0] b0, b1, b2);
    @(posedge ref_clk_i);
    #5;
    {op0_i, op1_i, op2_i, op3_i, cond_flags_i, start_i} = {b0, b1, b2, 8'h12, ~b1, 1'b1};
    @(posedge ref_clk_i);
    #5;
    start_i = 1'b0;
    chk(busy_o, 1'b1);
    for (n = 1; done_o !== 1'b1; n++) begin
      if (n > 20) begin
        bad_count++;
        end_of_test;
      end
      @(posedge ref_clk_i);
      #5;
    end
    chk(cond_flags_o, cond_flags_i);
  endtask
  task automatic t_store(input logic [15:0] sp, input logic [7:0] dd, input logic [15:0] a);
    logic [15:0] v;
    stack_ptr_i = sp;
    for (int s = 0; s < 4; s++) begin
      v = s == 0 ? pair_ba_i : s == 1 ? pair_ptr_i : s == 2 ? pair_ix1_i : pair_ix2_i;
      run(8'hCF, 8'h74 + 8'(s), dd);
      chk(n, 6);
      chk(wb_en_o, 1'b0);
      chk(wlse_mem_model_i.mem[a], v[7:0]);
      chk(wlse_mem_model_i.mem[a + 16'h1], v[15:8]);
      chk(wlse_mem_model_i.pg, paged_model_i ? data_page_i : 8'h00);
    end
  endtask
  task automatic t_load(input logic [7:0] dd, input logic [15:0] a);
    stack_ptr_i = 16'h2000;
    for (int s = 0; s < 4; s++) begin
      wlse_mem_model_i.mem[a] = 8'h64 + 8'(s);
      wlse_mem_model_i.mem[a + 16'h1] = 8'hE9;
      run(8'hCF, 8'h70 + 8'(s), dd);
      chk(n, 6);
      chk(wb_en_o, 1'b1);
      chk({wb_sp_o, wb_sel_o, wb_data_o}, {1'b0, 2'(s), 8'hE9, 8'h64 + 8'(s)});
    end
  endtask
  task automatic t_misc;
    run(8'hCF, 8'h6E, 8'h34);
    chk(n, 4);
    chk(wb_en_o, 1'b1);
    chk({wb_sp_o, wb_data_o}, {1'b1, 16'h1234});
    @(posedge ref_clk_i);
    #5;
    {op0_i, start_i} = {8'h00, 1'b1};
    @(posedge ref_clk_i);
    #5;
    start_i = 1'b0;
    chk({illegal_o, done_o}, 2'b10);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    #5;
    srst_i = 1'b0;
    t_store(16'h1280, 8'h80, 16'h1200);
    t_store(16'hFFF0, 8'h0F, 16'hFFFF);
    t_store(16'h0100, 8'h7F, 16'h017F);
    t_load(8'hFE, 16'h1FFE);
    t_misc;
    paged_model_i = 1'b0;
    t_store(16'h1280, 8'h80, 16'h1200);
    end_of_test;
  end
endmodule
bind wlse_core wlse_chk #(.PAGE_W(PAGE_W)) wlse_chk_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .start_i(start_i), .busy_o(busy_o), .op0_i(op0_i), .op1_i(op1_i), .op2_i(op2_i),
  .stack_ptr_i(stack_ptr_i), .cond_flags_i(cond_flags_i), .cond_flags_o(cond_flags_o),
  .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .done_o(done_o),
  .illegal_o(illegal_o));
`default_nettype wire
